// [sse_consts.vh]
// Constants for the secure serial memory access front end.
// Assumes a single 100 MHz system clock and a synchronous active-high reset.
`ifndef SSE_CONSTS_VH
`define SSE_CONSTS_VH
`define SSE_BIT_CYCLES     10'd512
`define SSE_HALF_CYCLES    10'd256
`define SSE_LAST_ADDR      9'h1FF
`define SSE_PROG_CYCLES    24'd1200000
`define SSE_CODE_MAX       4'h8
`define SSE_OP_LOCK        8'h88
`define SSE_OP_UNLOCK      8'hC5
`define SSE_OP_CHG_CODE    8'hC6
`define SSE_OP_BYPASS      8'hC7
`define SSE_OP_PTR_LOAD    8'hC4
`define SSE_OP_PTR_READ    8'hC8
`define SSE_OP_CLEAR_ALL   8'hC9
`define SSE_OP_FILL_ALL    8'hCA
`define SSE_OP_STREAM      8'hCB
`define SSE_OP_BUSY_ON     8'hCC
`define SSE_OP_BUSY_OFF    8'hCD
`define SSE_OP_PROG_ON     8'hCE
`define SSE_OP_PROG_OFF    8'hCF
`define SSE_OP_STATUS      8'hD0
`define SSE_OP_READ        8'hD1
`define SSE_OP_WRITE       8'hD2
`define SSE_OP_NOP         8'hD3
`define SSE_STAT_HEAD      3'h5
`endif

// [sse_fifo.v]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module sse_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             sys_clk,
    input  wire             reset,
    input  wire             flush,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            do_wr = in_valid && in_ready;
    wire            do_rd = out_valid && out_ready;
    assign in_ready  = (count != DEPTH) && !flush;
    assign out_valid = (count != 0) && !flush;
    assign out_data  = mem[rd_ptr];
    always @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always @(posedge sys_clk) begin
        if (reset || flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // sse_fifo

// [sse_access.v]
// Serial front end and access control of a secure serial memory.
// Assumes pins arrive asynchronously; the array lives in a local array here.
`timescale 1ns/1ns
`include "sse_consts.vh"
module sse_access (
    input  wire       sys_clk,
    input  wire       reset,
    input  wire       chip_select,
    input  wire       serial_in,
    input  wire       parity_select_in,
    output reg        serial_out,
    output reg        serial_out_en,
    output reg        fault_out,
    output reg        fault_out_en,
    output reg        secure_mode,
    output reg        busy
);
    localparam ST_IDLE = 3'h0;
    localparam ST_DATA = 3'h1;
    localparam ST_PAR  = 3'h2;
    localparam ST_STOP = 3'h3;
    localparam ST_HALT = 3'h4;
    localparam TX_IDLE = 2'h0;
    localparam TX_BIT  = 2'h1;
    localparam TX_GAP  = 2'h2;

    reg [2:0]  sync_cs;
    reg [2:0]  sync_di;
    reg [2:0]  sync_pe;
    reg        cs_q;
    reg        di_q;
    reg        pe_q;
    integer    s;
    always @(posedge sys_clk) begin
        if (reset) begin
            sync_cs <= 3'h0;
            sync_di <= 3'h7;
            sync_pe <= 3'h0;
            cs_q    <= 1'b0;
            di_q    <= 1'b1;
            pe_q    <= 1'b0;
        end else begin
            sync_cs <= {sync_cs[1:0], chip_select};
            sync_di <= {sync_di[1:0], serial_in};
            sync_pe <= {sync_pe[1:0], parity_select_in};
            if (sync_cs[2] == sync_cs[1]) cs_q <= sync_cs[2];
            if (sync_di[2] == sync_di[1]) di_q <= sync_di[2];
            if (sync_pe[2] == sync_pe[1]) pe_q <= sync_pe[2];
        end
    end

    reg [7:0]  mem [0:511];
    reg [7:0]  code [0:7];
    reg [3:0]  code_len;
    reg [8:0]  pointer;
    reg        prog_en;
    reg        access_en;
    reg        busy_sig_en;
    reg        bypass;
    reg        clear_all_armed;
    reg [23:0] prog_cnt;
    reg        prog_fill;
    reg        prog_all;
    reg [8:0]  prog_addr;
    reg [7:0]  prog_data;
    reg        par_err;
    reg        ins_err;
    reg        busy_hold;

    // Receiver.
    reg [2:0]  rx_state;
    reg [9:0]  rx_cnt;
    reg [2:0]  rx_bit;
    reg [7:0]  rx_shift;
    reg        rx_par;
    reg        rx_done;
    reg [7:0]  rx_byte;
    // Instruction decoder.
    reg [7:0]  op;
    reg [3:0]  nbytes;
    reg [3:0]  want;
    reg [8:0]  addr;
    reg [3:0]  cmp_idx;
    reg        cmp_ok;
    reg        streaming;
    reg [8:0]  rd_addr;
    // Transmitter and FIFO.
    reg [8:0]  fifo_in;
    reg        fifo_push;
    wire       fifo_ready;
    wire [8:0] fifo_out;
    wire       fifo_valid;
    reg        fifo_pop;
    reg [1:0]  tx_state;
    reg [9:0]  tx_cnt;
    reg [3:0]  tx_bit;
    reg [10:0] tx_shift;
    reg [3:0]  tx_last;

    sse_fifo #(.WIDTH(9), .DEPTH(16), .AW(4)) u_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .flush     (!cs_q),
        .in_data   (fifo_in),
        .in_valid  (fifo_push),
        .in_ready  (fifo_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    wire       below     = (addr < pointer);
    wire       secured   = (code_len != 4'h0);
    wire       rd_ok     = !secured || !below || access_en;
    wire       wr_ok     = prog_en && (secured ? (below && access_en) : (!below || bypass))
                           || (prog_en && !secured && bypass);
    wire       in_prog   = (prog_cnt != 24'h0);
    wire [7:0] status    = {`SSE_STAT_HEAD, par_err, ins_err, in_prog, 2'h0};

    always @(posedge sys_clk) begin
        if (reset) begin
            code_len        <= 4'h0;
            pointer         <= 9'h0;
            prog_en         <= 1'b0;
            access_en       <= 1'b0;
            busy_sig_en     <= 1'b0;
            bypass          <= 1'b0;
            clear_all_armed <= 1'b0;
            prog_cnt        <= 24'h0;
            prog_fill       <= 1'b0;
            prog_all        <= 1'b0;
            prog_addr       <= 9'h0;
            prog_data       <= 8'h0;
            par_err         <= 1'b0;
            ins_err         <= 1'b0;
            busy_hold       <= 1'b0;
            rx_state        <= ST_IDLE;
            rx_cnt          <= 10'h0;
            rx_bit          <= 3'h0;
            rx_shift        <= 8'h0;
            rx_par          <= 1'b0;
            rx_done         <= 1'b0;
            rx_byte         <= 8'h0;
            op              <= 8'h0;
            nbytes          <= 4'h0;
            want            <= 4'h0;
            addr            <= 9'h0;
            cmp_idx         <= 4'h0;
            cmp_ok          <= 1'b1;
            streaming       <= 1'b0;
            rd_addr         <= 9'h0;
            fifo_in         <= 9'h0;
            fifo_push       <= 1'b0;
        end else begin
            rx_done   <= 1'b0;
            fifo_push <= 1'b0;
            // program cycle runs on regardless of select.
            if (in_prog) begin
                prog_cnt <= prog_cnt - 24'h1;
                if (prog_cnt == 24'h1) begin
                    busy_hold <= 1'b1;
                    if (prog_all) begin
                        for (s = 0; s < 512; s = s + 1) mem[s] <= prog_fill ? prog_data : 8'hFF;
                    end else begin
                        mem[prog_addr] <= prog_data;
                    end
                end
            end
            if (!cs_q) begin
                // select low resets link logic only.
                rx_state  <= ST_IDLE;
                par_err   <= 1'b0;
                ins_err   <= 1'b0;
                op        <= 8'h0;
                nbytes    <= 4'h0;
                want      <= 4'h0;
                streaming <= 1'b0;
            end else begin
                case (rx_state)
                ST_IDLE: begin
                    if (!di_q) begin
                        rx_state <= ST_DATA;
                        rx_cnt   <= `SSE_BIT_CYCLES + `SSE_HALF_CYCLES;
                        rx_bit   <= 3'h0;
                    end
                end
                ST_DATA: begin
                    if (rx_cnt == 10'h0) begin
                        rx_shift <= {di_q, rx_shift[7:1]};
                        rx_cnt   <= `SSE_BIT_CYCLES - 10'd1;
                        rx_bit   <= rx_bit + 3'h1;
                        if (rx_bit == 3'h7) rx_state <= pe_q ? ST_PAR : ST_STOP;
                    end else begin
                        rx_cnt <= rx_cnt - 10'h1;
                    end
                end
                ST_PAR: begin
                    if (rx_cnt == 10'h0) begin
                        rx_par   <= di_q;
                        rx_cnt   <= `SSE_BIT_CYCLES - 10'd1;
                        rx_state <= ST_STOP;
                    end else begin
                        rx_cnt <= rx_cnt - 10'h1;
                    end
                end
                ST_STOP: begin
                    if (rx_cnt == 10'h0) begin
                        rx_state <= ST_IDLE;
                        if (pe_q && ((^rx_shift) != rx_par)) begin
                            par_err  <= 1'b1;
                            rx_state <= ST_HALT;
                        end else if (!di_q) begin
                            par_err  <= 1'b1;
                            rx_state <= ST_HALT;
                        end else begin
                            rx_done <= 1'b1;
                            rx_byte <= rx_shift;
                        end
                    end else begin
                        rx_cnt <= rx_cnt - 10'h1;
                    end
                end
                ST_HALT: begin
                    rx_state <= ST_HALT;
                end
                default: rx_state <= ST_IDLE;
                endcase
                if (streaming && fifo_ready && !fifo_push) begin
                    fifo_in   <= {^mem[rd_addr], mem[rd_addr]};
                    fifo_push <= 1'b1;
                    rd_addr   <= rd_addr + 9'h1;
                    if (rd_addr == `SSE_LAST_ADDR) streaming <= 1'b0;
                end
                if (rx_done && op == 8'h0) begin
                    if (prog_cnt != 24'h1) busy_hold <= 1'b0;
                    op        <= rx_byte;
                    nbytes    <= 4'h0;
                    cmp_idx   <= 4'h0;
                    cmp_ok    <= 1'b1;
                    case (rx_byte)
                    `SSE_OP_LOCK:      begin access_en <= 1'b0; op <= 8'h0; end
                    `SSE_OP_UNLOCK:    begin want <= code_len; if (!secured) op <= 8'h0; end
                    `SSE_OP_CHG_CODE:  want <= 4'h2;
                    `SSE_OP_BYPASS:    begin bypass <= 1'b1; op <= 8'h0; end
                    `SSE_OP_PTR_LOAD:  want <= 4'h2;
                    `SSE_OP_READ:      want <= 4'h2;
                    `SSE_OP_STREAM:    want <= 4'h2;
                    `SSE_OP_WRITE:     want <= 4'h3;
                    `SSE_OP_PTR_READ: begin
                        fifo_in <= {^pointer[7:0], pointer[7:0]};
                        fifo_push <= 1'b1;
                        op <= 8'h0;
                    end
                    `SSE_OP_STATUS: begin
                        fifo_in <= {^status, status};
                        fifo_push <= 1'b1;
                        op <= 8'h0;
                    end
                    `SSE_OP_CLEAR_ALL: begin
                        op <= 8'h0;
                        if (clear_all_armed && prog_en && !in_prog) begin
                            prog_all <= 1'b1; prog_fill <= 1'b0;
                            prog_cnt <= `SSE_PROG_CYCLES;
                            clear_all_armed <= 1'b0;
                        end else clear_all_armed <= 1'b1;
                    end
                    `SSE_OP_FILL_ALL:  begin want <= 4'h1; clear_all_armed <= 1'b0; end
                    `SSE_OP_BUSY_ON:   begin busy_sig_en <= 1'b1; op <= 8'h0; end
                    `SSE_OP_BUSY_OFF:  begin busy_sig_en <= 1'b0; op <= 8'h0; end
                    `SSE_OP_PROG_ON:   begin prog_en <= 1'b1; op <= 8'h0; end
                    `SSE_OP_PROG_OFF:  begin prog_en <= 1'b0; op <= 8'h0; end
                    `SSE_OP_NOP:       op <= 8'h0;
                    default: begin
                        ins_err  <= 1'b1;
                        rx_state <= ST_HALT;
                        op       <= 8'h0;
                    end
                    endcase
                end else if (rx_done) begin
                    nbytes <= nbytes + 4'h1;
                    if (op == `SSE_OP_UNLOCK) begin
                        if (rx_byte != code[cmp_idx[2:0]]) cmp_ok <= 1'b0;
                        cmp_idx <= cmp_idx + 4'h1;
                    end else if (op == `SSE_OP_CHG_CODE) begin
                        if (nbytes == 4'h0) begin
                            want     <= {1'b0, rx_byte[2:0]} + 4'h2;
                            code_len <= 4'h0;
                        end else begin
                            code[nbytes[2:0] - 3'h1] <= rx_byte;
                        end
                    end else if (nbytes == 4'h0) begin
                        addr <= {rx_byte[0], 8'h0};
                        if (op == `SSE_OP_FILL_ALL) prog_data <= rx_byte;
                    end else if (nbytes == 4'h1) begin
                        addr <= {addr[8], rx_byte};
                    end else begin
                        prog_data <= rx_byte;
                    end
                    if (nbytes + 4'h1 == want) begin
                        op <= 8'h0;
                        case (op)
                        `SSE_OP_UNLOCK: begin
                            if (cmp_ok && rx_byte == code[cmp_idx[2:0]]) access_en <= 1'b1;
                        end
                        `SSE_OP_CHG_CODE: begin
                            if (want > `SSE_CODE_MAX + 4'h1) code_len <= `SSE_CODE_MAX;
                            else code_len <= want - 4'h1;
                        end
                        `SSE_OP_PTR_LOAD: begin
                            if (!secured || access_en) pointer <= {addr[8], rx_byte};
                        end
                        `SSE_OP_READ: begin
                            if (!secured || !({addr[8], rx_byte} < pointer) || access_en) begin
                                fifo_in   <= {^mem[{addr[8], rx_byte}], mem[{addr[8], rx_byte}]};
                                fifo_push <= 1'b1;
                            end
                        end
                        `SSE_OP_STREAM: begin
                            streaming <= rd_ok;
                            rd_addr   <= {addr[8], rx_byte};
                        end
                        `SSE_OP_WRITE: begin
                            if (wr_ok && !in_prog) begin
                                prog_all  <= 1'b0;
                                prog_addr <= addr;
                                prog_cnt  <= `SSE_PROG_CYCLES;
                            end
                            bypass <= 1'b0;
                        end
                        `SSE_OP_FILL_ALL: begin
                            if (prog_en && !in_prog) begin
                                prog_all <= 1'b1; prog_fill <= 1'b1;
                                prog_cnt <= `SSE_PROG_CYCLES;
                            end
                        end
                        default: op <= 8'h0;
                        endcase
                    end
                end
            end
        end
    end

    always @(posedge sys_clk) begin
        if (reset || !cs_q) begin
            tx_state <= TX_IDLE;
            tx_cnt   <= 10'h0;
            tx_bit   <= 4'h0;
            tx_shift <= 11'h7FF;
            tx_last  <= 4'h0;
            fifo_pop <= 1'b0;
        end else begin
            fifo_pop <= 1'b0;
            case (tx_state)
            TX_IDLE: begin
                if (fifo_valid && !fifo_pop) begin
                    fifo_pop <= 1'b1;
                    tx_shift <= {1'b1, fifo_out[8], fifo_out[7:0], 1'b0};
                    tx_last  <= pe_q ? 4'hA : 4'h9;
                    if (!pe_q) tx_shift <= {2'h3, fifo_out[7:0], 1'b0};
                    tx_bit   <= 4'h0;
                    tx_cnt   <= `SSE_BIT_CYCLES - 10'd1;
                    tx_state <= TX_BIT;
                end
            end
            TX_BIT: begin
                if (tx_cnt == 10'h0) begin
                    tx_cnt   <= `SSE_BIT_CYCLES - 10'd1;
                    tx_shift <= {1'b1, tx_shift[10:1]};
                    tx_bit   <= tx_bit + 4'h1;
                    if (tx_bit == tx_last) tx_state <= TX_GAP;
                end else begin
                    tx_cnt <= tx_cnt - 10'h1;
                end
            end
            TX_GAP: tx_state <= TX_IDLE;
            default: tx_state <= TX_IDLE;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            serial_out    <= 1'b1;
            serial_out_en <= 1'b0;
            fault_out     <= 1'b0;
            fault_out_en  <= 1'b0;
            secure_mode   <= 1'b0;
            busy          <= 1'b0;
        end else begin
            secure_mode  <= secured;
            busy         <= in_prog;
            fault_out    <= 1'b0;
            fault_out_en <= par_err || ins_err;
            // drive only for data or busy.
            if (!cs_q || par_err || ins_err) begin
                serial_out_en <= 1'b0;
                serial_out    <= 1'b1;
            // status goes through the data path.
            end else if (tx_state == TX_BIT) begin
                serial_out_en <= 1'b1;
                serial_out    <= tx_shift[0];
            end else if (busy_sig_en && (in_prog || busy_hold)) begin
                serial_out_en <= 1'b1;
                serial_out    <= !in_prog;
            end else begin
                serial_out_en <= 1'b0;
                serial_out    <= 1'b1;
            end
        end
    end
endmodule // sse_access

// [sse_monitor.sv]
// Checker on the ports of sse_access.
// Bound into every sse_access instance below.
`timescale 1ns/1ns
module sse_monitor (
    input wire sys_clk,
    input wire reset,
    input wire chip_select,
    input wire serial_out,
    input wire serial_out_en,
    input wire fault_out_en,
    input wire secure_mode,
    input wire busy
);
    reg [20:0] busy_cnt;
    always @(posedge sys_clk) begin
        busy_cnt <= busy ? busy_cnt + 21'h1 : 21'h0;
    end
    reg [9:0]  low_cnt;
    always @(posedge sys_clk) begin
        if (serial_out_en && !serial_out) begin
            low_cnt <= (low_cnt == 10'h3FF) ? low_cnt : low_cnt + 10'h1;
        end else begin
            low_cnt <= 10'h0;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_fault_hold: assert property (fault_out_en && chip_select |=> fault_out_en)
        else $error("fault released");
    chk_error_float: assert property (fault_out_en |-> !serial_out_en)
        else $error("output driven in error");
    chk_desel_float: assert property (!chip_select [*8] |-> ##2 !serial_out_en)
        else $error("output driven when deselected");
    chk_mode_keep: assert property (!chip_select |=> $stable(secure_mode))
        else $error("mode changed by deselect");
    chk_prog_len: assert property ($fell(busy) |-> busy_cnt > 21'h0F4240)
        else $error("program cycle cut short");
    chk_start_low: assert property ($rose(serial_out_en) |-> !serial_out)
        else $error("no start bit");
    chk_start_width: assert property (serial_out_en && $rose(serial_out) |-> low_cnt >= 10'd500)
        else $error("low bit short");
    chk_stop_high: assert property ($fell(serial_out_en) && chip_select && !fault_out_en
        |-> $past(serial_out)) else $error("no stop bit");
    cover property ($rose(busy));
    cover property ($rose(fault_out_en));
    cover property ($rose(secure_mode));
endmodule // sse_monitor
bind sse_access sse_monitor mon (.sys_clk(sys_clk), .reset(reset), .chip_select(chip_select),
    .serial_out(serial_out), .serial_out_en(serial_out_en), .fault_out_en(fault_out_en),
    .secure_mode(secure_mode), .busy(busy));

// [sse_host.sv]
// Host side of the serial link: sends and receives byte frames.
// Assumes 512 clocks per bit; parity follows the parity select pin.
`timescale 1ns/1ns
module sse_host (
    input  wire sys_clk,
    input  wire par_on,
    input  wire serial_out,
    input  wire serial_out_en,
    output reg  serial_in
);
    initial serial_in = 1'b1;
    task send(input [7:0] b, input bad);
        reg [10:0] f;
        integer    i;
        begin
            f = par_on ? {1'b1, ^b ^ bad, b, 1'b0} : {2'b11, b, 1'b0};
            for (i = 0; i < 10 + par_on; i = i + 1) begin
                @(posedge sys_clk) serial_in <= f[i];
                repeat (511) @(posedge sys_clk);
            end
        end
    endtask
    task recv(output [8:0] r);
        integer k;
        begin
            r = 9'h1FF;
            k = 0;
            while (!(serial_out_en === 1'b1 && serial_out === 1'b0) && k < 40000) begin
                @(posedge sys_clk);
                k = k + 1;
            end
            repeat (256) @(posedge sys_clk);
            for (k = 0; k < 8 + par_on; k = k + 1) begin
                repeat (512) @(posedge sys_clk);
                r[k] = serial_out;
            end
        end
    endtask
endmodule // sse_host

// [tb_top.sv]
// Self-checking bench for the serial access front end.
// Drives reset, select and parity; the host model works the link.
`timescale 1ns/1ns
module tb_top;
    reg       sys_clk = 1'b0;
    reg       reset = 1'b1;
    reg       chip_select = 1'b0;
    reg       parity_select_in = 1'b0;
    reg [8:0] r;
    integer   n_errors = 0;
    integer   n_checks = 0;
    wire      serial_in, serial_out, serial_out_en, fault_out, fault_out_en, secure_mode, busy;
    always #5 sys_clk = ~sys_clk;
    sse_access uut (.sys_clk(sys_clk), .reset(reset), .chip_select(chip_select),
        .serial_in(serial_in), .parity_select_in(parity_select_in), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .fault_out(fault_out), .fault_out_en(fault_out_en),
        .secure_mode(secure_mode), .busy(busy));
    sse_host host (.sys_clk(sys_clk), .par_on(parity_select_in), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .serial_in(serial_in));
    task check(input [8:0] got, input [8:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tx(input [47:0] w, input integer n);
        integer i;
        begin
            for (i = n - 1; i >= 0; i = i - 1) host.send(w[8*i +: 8], 1'b0);
            repeat (16) @(posedge sys_clk);
        end
    endtask
    task desel(input [8:0] exp);
        begin
            chip_select <= 1'b0;
            repeat (20) @(posedge sys_clk);
            check(9'({busy, secure_mode, serial_out_en, fault_out_en}), exp);
            chip_select <= 1'b1;
            repeat (20) @(posedge sys_clk);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        #2000000;
        n_errors = n_errors + 1;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        chip_select <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check(9'({busy, secure_mode, serial_out_en, fault_out_en}), 9'h000);
        host.send(8'h00, 1'b0);
        repeat (600) @(posedge sys_clk);
        check(9'({fault_out, fault_out_en, serial_out_en}), 9'h002);
        desel(9'h000);
        $display("bad opcode test done");
        parity_select_in <= 1'b1;
        repeat (8) @(posedge sys_clk);
        host.send(8'hD0, 1'b1);
        repeat (600) @(posedge sys_clk);
        check(9'(fault_out_en), 9'h001);
        desel(9'h000);
        fork
            host.send(8'hD0, 1'b0);
            host.recv(r);
        join
        check(r, 9'h0A0);
        $display("parity and status test done");
        repeat (1000) @(posedge sys_clk);
        parity_select_in <= 1'b0;
        repeat (8) @(posedge sys_clk);
        tx(48'hCEC6005A, 4);
        check(9'(secure_mode), 9'h001);
        tx(48'hD20010AA, 4);
        check(9'({busy, serial_out_en}), 9'h000);
        desel(9'h004);
        $display("secure mode test done");
        reset <= 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check(9'(secure_mode), 9'h000);
        tx(48'hCCCED20010AA, 6);
        check(9'({busy, serial_out_en, serial_out}), 9'h006);
        desel(9'h008);
        $display("busy and deselect test done");
        end_sim;
    end
endmodule // tb_top
